// ### pkg/shcrc_pkg.sv
/*
 * Shared constants and types for the serial host CRC checker.
 * Assumes one host on the serial control port, shifting MSB first.
 */
package shcrc_pkg;

   // ------------------------------------------------------------
   // Check arithmetic
   // ------------------------------------------------------------
   localparam int CRC_W = 16;
   localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
   localparam logic [CRC_W-1:0] CRC_INIT = 16'h0000;
   localparam logic [CRC_W-1:0] EXP_RESET = 16'h0000;

   // ------------------------------------------------------------
   // Serial command framing
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_REM = 8'hB6;
   localparam logic [7:0] CMD_READ_REM = 8'hD6;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CMD_BITS = 5'h08;
   localparam logic [CNT_W-1:0] UNIT_BITS = 5'h18;
   localparam int PIN_STAGES = 3;
   localparam int RST_STAGES = 2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic {
      ST_IDLE,
      ST_FRAME
   } shcrc_state_e;

   typedef struct packed {
      logic [CRC_W-1:0] computed;
      logic [CRC_W-1:0] expected;
   } shcrc_result_s;

endpackage : shcrc_pkg

// ### rtl/shcrc_sync.sv
/*
 * Flip-flop chain synchroniser, all stages visible.
 * Assumes the caller reads only stages from index 1 upward.
 */
`timescale 1ns/1ps
module shcrc_sync #(
   parameter int STAGES = 3,
   parameter logic INIT = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic din,
   output logic [STAGES-1:0] q
);

   logic [STAGES-1:0] q_nxt;

   always_comb begin
      q_nxt = {q[STAGES-2:0], din};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= {STAGES{INIT}};
      end else begin
         q <= q_nxt;
      end
   end

endmodule : shcrc_sync

// ### rtl/shcrc_top.sv
/*
 * Serial host CRC checker: CRC over each strobed frame, expected
 * remainder load and readback, match indication on the serial output.
 * Assumes the shift clock stands still while request_strobe_n is high.
 */
//
// Contract
// - CRC covers every input bit while the request strobe is low.
// - Generator polynomial is x^16+x^12+x^5+1, full form 11021h.
// - Remainder is mod-2 division after 16 appended zeros, 16 bits.
// - Command D6h returns stored remainder, upper byte then lower byte.
// - Comparison runs whether or not the remainder was read back.
// - Output high from strobe rise to next fall on match, else low.
// - Host readout on the serial output overrides the match indication.
// - Readout data change on the falling shift clock edge.
`timescale 1ns/1ps
module shcrc_top
   import shcrc_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Serial control port
   input wire logic shift_clk,
   input wire logic request_strobe_n,
   input wire logic serial_in,
   output logic serial_out
);

   import shcrc_pkg::*;

   // ------------------------------------------------------------
   // Core domain: strobe tracking and comparison
   // ------------------------------------------------------------
   logic [PIN_STAGES-1:0] stb_q;
   logic stb_stable;
   shcrc_state_e state_r, state_nxt;
   logic ind_r, ind_nxt;
   logic epoch_r, epoch_nxt;
   shcrc_result_s result;

   // Link-side state, declared here so the core can read it at frame end
   logic [CRC_W-1:0] crc_r, crc_nxt;
   logic [CRC_W-1:0] exp_r, exp_nxt;

   shcrc_sync #(
      .STAGES(PIN_STAGES),
      .INIT(1'b1)
   ) u_stb_sync (
      .clk(core_clk),
      .rst(reset),
      .din(request_strobe_n),
      .q(stb_q)
   );

   assign stb_stable = (stb_q[1] == stb_q[2]);

   // Link registers are frozen once the strobe is high and the shift clock idles
   assign result = '{computed: crc_r, expected: exp_r};

   always_comb begin
      state_nxt = state_r;
      ind_nxt = ind_r;
      epoch_nxt = epoch_r;
      case (state_r)
         ST_IDLE: begin
            if (stb_stable && !stb_q[2]) begin
               state_nxt = ST_FRAME;
               ind_nxt = 1'b0;
            end
         end
         ST_FRAME: begin
            if (stb_stable && stb_q[2]) begin
               state_nxt = ST_IDLE;
               // Compared every frame, readback or not
               ind_nxt = (result.computed == result.expected);
               // Tells the link side to restart its sums on the next frame
               epoch_nxt = ~epoch_r;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            ind_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= ST_IDLE;
         ind_r <= 1'b0;
         // Starts opposite the link's seen flag, so the first frame restarts its sums
         epoch_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         ind_r <= ind_nxt;
         epoch_r <= epoch_nxt;
      end
   end

   // ------------------------------------------------------------
   // Link domain: reset crossing
   // ------------------------------------------------------------
   logic [RST_STAGES-1:0] lrst_q;
   logic link_rst;

   shcrc_sync #(
      .STAGES(RST_STAGES),
      .INIT(1'b1)
   ) u_rst_sync (
      .clk(shift_clk),
      .rst(1'b0),
      .din(reset),
      .q(lrst_q)
   );

   assign link_rst = lrst_q[RST_STAGES-1];

   // ------------------------------------------------------------
   // Link domain: CRC, command decode, remainder load
   // ------------------------------------------------------------
   logic seen_r, seen_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [23:0] sh_r, sh_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic fresh;
   logic [CNT_W-1:0] cnt_base;
   logic [CRC_W-1:0] crc_base;
   logic [23:0] sh_base;
   logic fb;

   // epoch_r only moves between frames, so it is steady across every edge here
   assign fresh = (seen_r != epoch_r);

   always_comb begin
      seen_nxt = seen_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      cmd_nxt = cmd_r;
      crc_nxt = crc_r;
      exp_nxt = exp_r;
      cnt_base = fresh ? '0 : cnt_r;
      crc_base = fresh ? CRC_INIT : crc_r;
      sh_base = fresh ? '0 : sh_r;
      fb = crc_base[CRC_W-1] ^ serial_in;
      if (!request_strobe_n) begin
         seen_nxt = epoch_r;
         // MSB-first shift; feeding the message at the top folds in the 16 zeros
         crc_nxt = {crc_base[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
         sh_nxt = {sh_base[22:0], serial_in};
         if (cnt_base != UNIT_BITS) begin
            cnt_nxt = cnt_base + 5'h01;
         end else begin
            cnt_nxt = cnt_base;
         end
         if (cnt_base == CMD_BITS - 5'h01) begin
            cmd_nxt = {sh_base[6:0], serial_in};
         end else if (fresh) begin
            cmd_nxt = '0;
         end
         if (cnt_base == UNIT_BITS - 5'h01 && cmd_r == CMD_WRITE_REM) begin
            exp_nxt = {sh_base[14:0], serial_in};
         end
      end
   end

   always_ff @(posedge shift_clk) begin
      if (link_rst) begin
         seen_r <= 1'b0;
         cnt_r <= UNIT_BITS;
         sh_r <= '0;
         cmd_r <= '0;
         crc_r <= CRC_INIT;
         exp_r <= EXP_RESET;
      end else begin
         seen_r <= seen_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         cmd_r <= cmd_nxt;
         crc_r <= crc_nxt;
         exp_r <= exp_nxt;
      end
   end

   // ------------------------------------------------------------
   // Link domain: remainder readback on the falling edge
   // ------------------------------------------------------------
   logic rd_act_r, rd_act_nxt;
   logic rd_bit_r, rd_bit_nxt;
   logic [CNT_W-1:0] rd_idx;

   always_comb begin
      rd_idx = cnt_r - CMD_BITS;
      rd_act_nxt = 1'b0;
      rd_bit_nxt = 1'b0;
      if (!fresh && cmd_r == CMD_READ_REM && cnt_r >= CMD_BITS && cnt_r < UNIT_BITS) begin
         rd_act_nxt = 1'b1;
         rd_bit_nxt = exp_r[4'hF - rd_idx[3:0]];
      end
   end

   always_ff @(negedge shift_clk) begin
      if (link_rst) begin
         rd_act_r <= 1'b0;
         rd_bit_r <= 1'b0;
      end else begin
         rd_act_r <= rd_act_nxt;
         rd_bit_r <= rd_bit_nxt;
      end
   end

   // ------------------------------------------------------------
   // Serial output
   // ------------------------------------------------------------
   // Readout is only honoured inside a frame seen by the core; a readout cut short
   // leaves rd_act_r set, so it is also masked until the next unit reaches its data bits
   assign serial_out = (rd_act_r && !fresh && cnt_r >= CMD_BITS && state_r == ST_FRAME) ?
      rd_bit_r : ind_r;

endmodule : shcrc_top

// ### test/shcrc_properties.sv
/* Checker on the serial checker pins.
   Assumes the host idles shift_clk outside frames. */
`timescale 1ns/1ps
module shcrc_properties (
   // Watched pins
   input wire logic core_clk,
   input wire logic reset,
   input wire logic shift_clk,
   input wire logic request_strobe_n,
   input wire logic serial_in,
   input wire logic serial_out
);
   logic rise_out_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   always_ff @(posedge shift_clk) rise_out_r <= serial_out;
   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !serial_out)
      else $error("high in reset");
   a_leave_reset: assert property ($fell(reset) |-> !serial_out[*2])
      else $error("high after reset");
   a_idle_stable: assert property (request_strobe_n[*6] |-> $stable(serial_out))
      else $error("idle change");
   a_frame_low: assert property ((!request_strobe_n && !shift_clk)[*7] |-> !serial_out)
      else $error("frame not low");
   a_fall_clear: assert property ($fell(request_strobe_n) |-> ##6 !serial_out)
      else $error("not cleared");
   a_match_rise: assert property (
      $rose(serial_out) && request_strobe_n |-> !$past(request_strobe_n, 6)) else $error("late");
   a_miss_fall: assert property (
      $fell(serial_out) && request_strobe_n |-> !$past(request_strobe_n, 6)) else $error("late");
   a_read_edge: assert property (@(negedge shift_clk)
      !request_strobe_n |-> serial_out == rise_out_r) else $error("mid-bit change");
endmodule : shcrc_properties
bind shcrc_top shcrc_properties shcrc_properties_i (.core_clk(core_clk), .reset(reset),
   .shift_clk(shift_clk), .request_strobe_n(request_strobe_n), .serial_in(serial_in),
   .serial_out(serial_out));

// ### test/shcrc_host.sv
/* Host model: framed serial units, output sampled on rising shift edges.
   Assumes core_clk paces the strobe. */
`timescale 1ns/1ps
module shcrc_host (
   // Pacing clock
   input wire logic core_clk,
   // Serial control port
   output logic shift_clk,
   output logic request_strobe_n,
   output logic serial_in,
   input wire logic serial_out
);
   initial begin
      shift_clk = 1'b0;
      request_strobe_n = 1'b1;
      serial_in = 1'b0;
   end
   // Bare pulses with the strobe high carry reset into and out of the link side
   task automatic pulse(input int n);
      repeat (n) begin
         #7.5 shift_clk = 1'b1;
         #7.5 shift_clk = 1'b0;
      end
   endtask : pulse
   task automatic frame(input logic [87:0] d, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      @(negedge core_clk) request_strobe_n <= 1'b0;
      repeat (8) @(negedge core_clk);
      #3;
      for (int k = n - 1; k >= 0; k--) begin
         serial_in = d[k];
         #7.5 shift_clk = 1'b1;
         rd = {rd[14:0], serial_out};
         #7.5 shift_clk = 1'b0;
      end
      // A released line must not keep its last value
      serial_in = ~serial_in;
      repeat (2) @(negedge core_clk);
      request_strobe_n <= 1'b1;
      repeat (8) @(negedge core_clk);
   endtask : frame
endmodule : shcrc_host

// ### test/tb_shcrc_top.sv
/* Bench: random remainders and messages against a bench CRC.
   Assumes the host model shcrc_host. */
`timescale 1ns/1ps
module tb_shcrc_top;
   import shcrc_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic shift_clk, request_strobe_n, serial_in, serial_out;
   int err_count = 0;
   int num_checks = 0;
   int seed = 94345;
   int n;
   logic [15:0] r, rd;
   logic [87:0] msg;
   logic [7:0] op;
   always #12.5 core_clk = ~core_clk;
   shcrc_top shcrc_top_i (.core_clk(core_clk), .reset(reset), .shift_clk(shift_clk),
      .request_strobe_n(request_strobe_n), .serial_in(serial_in), .serial_out(serial_out));
   shcrc_host shcrc_host_i (.core_clk(core_clk), .shift_clk(shift_clk),
      .request_strobe_n(request_strobe_n), .serial_in(serial_in), .serial_out(serial_out));
   function automatic logic [15:0] crc(input logic [87:0] d, input int n);
      logic [15:0] c;
      c = 16'h0000;
      for (int k = n - 1; k >= 0; k--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction : crc
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic ind(input logic [87:0] d, input int n);
      chk("match", {15'h0000, crc(d, n) == r}, {15'h0000, serial_out});
   endtask : ind
   task automatic results();
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   task automatic reset_seq();
      reset <= 1'b1;
      repeat (4) @(negedge core_clk);
      // The link side only sees reset change while its clock runs
      shcrc_host_i.pulse(4);
      repeat (10) @(negedge core_clk);
      reset <= 1'b0;
      repeat (2) @(negedge core_clk);
      shcrc_host_i.pulse(3);
   endtask : reset_seq
   initial begin
      reset_seq();
      shcrc_host_i.frame(88'hD60000, 24, rd);
      chk("reset value", EXP_RESET, rd);
      for (int i = 0; i < 8; i++) begin
         n = 40;
         op = (i % 4 == 1) ? 8'hA4 : (i % 4 == 3) ? 8'h94 : 8'h5A;
         msg = {48'h0, op, 32'($random(seed))};
         r = (i % 2 == 1) ? crc(msg, n) ^ (16'h0001 << i) : crc(msg, n);
         if (i == 0) begin
            msg = 88'hD2A5A5;
            n = 24;
            r = 16'h0C30;
         end
         if (i == 2) begin
            msg = 88'hA855557777AAAA0000FFFF;
            n = 88;
            r = 16'h2297;
         end
         shcrc_host_i.frame({64'h0, CMD_WRITE_REM, r}, 24, rd);
         ind({64'h0, CMD_WRITE_REM, r}, 24);
         if (i % 3 != 2) begin
            shcrc_host_i.frame({64'h0, CMD_READ_REM, 16'h0000}, 24, rd);
            chk("readback", r, rd);
            ind(88'hD60000, 24);
         end
         shcrc_host_i.frame(msg, n, rd);
         ind(msg, n);
      end
      // Readout cut short, then a load too short to land: neither may leave state behind
      shcrc_host_i.frame(88'hD60, 12, rd);
      chk("cut readback", {12'h000, r[15:12]}, {12'h000, rd[3:0]});
      ind(88'hD60, 12);
      shcrc_host_i.frame({72'h0, CMD_WRITE_REM, 8'hFF}, 16, rd);
      ind({72'h0, CMD_WRITE_REM, 8'hFF}, 16);
      shcrc_host_i.frame(88'hD60000, 24, rd);
      chk("short load", r, rd);
      // Reset in mid-run must return the stored remainder to its reset value
      reset_seq();
      shcrc_host_i.frame(88'hD60000, 24, rd);
      chk("reset value", EXP_RESET, rd);
      results();
   end
   initial begin
      #200us;
      err_count++;
      results();
   end
endmodule : tb_shcrc_top
